// ==== hdl/rsbi_defs.svh ====
// Purpose: Constants of the reset strap and bus init block
// Assumes: Oscillator clock at 10 MHz, processor clock is half of it
// Notes: Included by the package and by the top-level design file
`ifndef RSBI_DEFS_SVH
`define RSBI_DEFS_SVH
// ==========================================================
// Clock division and reset timing
`define RSBI_CLK_DIV 2
`define RSBI_RST_DRIVE 2'h2
`define RSBI_MIN_STATES 4'h4
// ==========================================================
// Bus widths and status codes
`define RSBI_ADDR_W 20
`define RSBI_DATA_W 16
`define RSBI_UPPER_W 4
`define RSBI_STAT_PASSIVE 3'h7
`define RSBI_STAT_MEM_RD 3'h5
`define RSBI_STAT_MEM_WR 3'h6
// ==========================================================
// Pull-up enable bits
`define RSBI_PU_RD 0
`define RSBI_PU_UPPER 1
`define RSBI_PU_LOWER 2
`define RSBI_PU_MID0 3
`define RSBI_PU_MID1 4
`define RSBI_PU_BUSY 5
`define RSBI_PU_ALL 6'h3f
`define RSBI_PU_NONE 6'h00
`endif

// ==== hdl/rsbi_pkg.sv ====
// Purpose: Types of the reset strap and bus init block
// Assumes: rsbi_defs.svh gives the widths
// Notes: Bus states use Gray codes along the usual cycle path from ST_IDLE to ST_T4
`include "rsbi_defs.svh"

package rsbi_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h3,
        ST_T3 = 3'h2,
        ST_T4 = 3'h6,
        ST_TW = 3'h7,
        ST_HOLD = 3'h4
    } rsbi_state_e;

    typedef struct packed {
        logic write;
        logic [`RSBI_ADDR_W-1:0] addr;
        logic [`RSBI_DATA_W-1:0] wdata;
    } rsbi_req_s;

    typedef struct packed {
        logic queue_status;
        logic pin_float;
        logic enhanced;
    } rsbi_mode_s;

    typedef struct packed {
        logic rd;
        logic upper;
        logic lower;
        logic busy;
    } rsbi_strap_s;
endpackage : rsbi_pkg

// ==== hdl/rsbi_clkdiv.sv ====
// Purpose: Divide-by-two counter for processor clock and phase enables
// Assumes: core_clk is the oscillator input
// Notes: Phase restarts at zero out of reset
`timescale 1ns/10ps

module rsbi_clkdiv (
    input wire logic core_clk, // Oscillator clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    output logic processor_clock_out, // Half-rate clock, 50% duty
    output logic phase_one, // First internal phase enable
    output logic phase_two // Second internal phase enable
);
    import rsbi_pkg::*;

    logic phase;

    // ==========================================================
    // Single counter feeds every phase and the clock pin
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (!rst_n) begin
                phase <= 1'b0;
            end else begin
                phase <= ~phase;
            end
        end
    end

    // Both enables come from the same bit so they never drift apart
    assign processor_clock_out = phase;
    assign phase_one = phase;
    assign phase_two = ~phase;

    chk_processor_clock_out_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce |=> processor_clock_out != $past(processor_clock_out))
        else $error("processor clock did not toggle");

    chk_phase_known: assert property (@(posedge core_clk)
        (!rst_n && ce) ##1 (rst_n && ce) |-> !processor_clock_out ##1 processor_clock_out)
        else $error("processor clock phase wrong after reset");
endmodule : rsbi_clkdiv

// ==== hdl/rsbi_strap.sv ====
// Purpose: Strap sampling, pull-up control and mode latch
// Assumes: Strap pins are floated by the bus logic by the end of the first processor clock of reset
// Notes: Modes hold until the next reset
`timescale 1ns/10ps

module rsbi_strap (
    input wire logic core_clk, // Oscillator clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire rsbi_pkg::rsbi_strap_s strap, // Strap pin levels
    output rsbi_pkg::rsbi_mode_s mode, // Latched operating modes
    output logic [5:0] pullup_en, // Internal pull-up enables
    output logic reset_out // Reset output, high in reset
);
    import rsbi_pkg::*;

    logic in_rst;
    logic busy_low;

    // ==========================================================
    // Pull-ups and reset output follow reset
    always_ff @(posedge core_clk) begin
        if (ce) begin
            pullup_en <= !rst_n ? `RSBI_PU_ALL : `RSBI_PU_NONE;
            reset_out <= !rst_n;
        end
    end

    // ==========================================================
    // Rd and select straps read on the release edge, when the bus pins are already floated
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (!rst_n) begin
                in_rst <= 1'b1;
                mode <= '0;
                // Busy taken at reset entry, before reset_out rises, so a tie works
                if (!in_rst) begin
                    busy_low <= !strap.busy;
                end
            end else begin
                in_rst <= 1'b0;
                if (in_rst) begin
                    mode.queue_status <= !strap.rd;
                    mode.pin_float <= !strap.upper && !strap.lower;
                end
                if (busy_low && strap.busy) begin
                    mode.enhanced <= 1'b1;
                end
            end
        end
    end

    chk_strap_queue: assert property (@(posedge core_clk)
        (!rst_n && ce) ##1 (rst_n && ce && !strap.rd) |=> mode.queue_status)
        else $error("queue status strap not latched");

    chk_strap_float: assert property (@(posedge core_clk)
        (!rst_n && ce) ##1 (rst_n && ce && !strap.upper && !strap.lower)
        |=> mode.pin_float)
        else $error("pin float strap not latched");

    chk_enh_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(mode.enhanced) |-> $past(strap.busy) && busy_low)
        else $error("enhanced mode without busy strap sequence");
endmodule : rsbi_strap

// ==== hdl/rsbi_top.sv ====
// Purpose: Reset-time pin control, strap modes and local bus cycles
// Assumes: All inputs synchronous to core_clk; pins split into in/out/enable
// Notes: One bus cycle is T1,T2,T3,(TW..),T4 stepped on the processor phase
`timescale 1ns/10ps
`include "rsbi_defs.svh"

module rsbi_top (
    input wire logic core_clk, // Oscillator clock, 10 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire rsbi_pkg::rsbi_req_s req_data, // Bus request contents
    input wire logic req_valid, // Request offered
    output logic req_ready, // Request can be taken
    output logic rsp_valid, // Cycle finished, one-cycle pulse
    output logic [15:0] rsp_rdata, // Read data of finished cycle
    input wire logic [1:0] queue_state_in, // Queue state from the core
    input wire logic bus_ready, // Ready input, high means ready
    input wire logic hold_req, // Hold request from another master
    output logic bus_grant_out, // Hold acknowledge
    output logic bus_grant_oe, // Grant pin enable
    output logic processor_clock_out, // Processor clock
    input wire logic [15:0] muxed_addr_data_i, // Address/data pins in
    output logic [15:0] muxed_addr_data_o, // Address/data pins out
    output logic muxed_addr_data_oe, // Address/data enable
    output logic [3:0] upper_address_o, // Upper address
    output logic upper_address_oe, // Upper address enable
    output logic high_byte_enable_n, // High byte enable, active low
    output logic high_byte_enable_oe, // High byte enable pin enable
    output logic address_latch_strobe, // Latch strobe or queue state bit 0
    output logic address_latch_oe, // Latch strobe enable
    input wire logic read_strobe_queue_strap_i, // Read pin level
    output logic read_strobe_n, // Read strobe, active low
    output logic read_strobe_oe, // Read strobe enable
    output logic write_strobe_n, // Write strobe or queue state bit 1
    output logic write_strobe_oe, // Write strobe enable
    output logic transceiver_enable_n, // Transceiver enable, active low
    output logic transceiver_enable_oe, // Transceiver enable pin enable
    output logic transceiver_direction, // High for write
    output logic transceiver_direction_oe, // Direction enable
    output logic [2:0] bus_cycle_status, // Cycle status code
    output logic bus_cycle_status_oe, // Status enable
    output logic bus_lock_out_n, // Lock, active low
    output logic bus_lock_out_oe, // Lock enable
    input wire logic [3:0] mem_select_i, // Select pin levels, upper,lower,mid0,mid1
    output logic [3:0] mem_select_n, // Select outputs, inactive high
    output logic mem_select_oe, // Select enable
    input wire logic coproc_busy_test_in, // Busy/test input
    output logic [5:0] strap_pullup_en, // Internal pull-up enables
    output logic reset_out, // Reset output
    output rsbi_pkg::rsbi_mode_s mode // Latched modes
);
    import rsbi_pkg::*;

    rsbi_state_e state;
    rsbi_req_s cur;
    rsbi_strap_s strap;
    logic pending;
    logic [1:0] rst_cnt;
    logic drive;
    logic tick;
    logic [3:0] st_cnt;

    assign strap = '{rd: read_strobe_queue_strap_i, upper: mem_select_i[0],
        lower: mem_select_i[1], busy: coproc_busy_test_in};
    assign drive = rst_cnt != `RSBI_RST_DRIVE;

    // ==========================================================
    // Clock generator and straps
    rsbi_clkdiv u_clkdiv (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .processor_clock_out(processor_clock_out),
        .phase_one(tick),
        .phase_two()
    );

    rsbi_strap u_strap (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .strap(strap),
        .mode(mode),
        .pullup_en(strap_pullup_en),
        .reset_out(reset_out)
    );

    // ==========================================================
    // Reset window counter, one processor clock of drive
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (!rst_n) begin
                rst_cnt <= drive ? rst_cnt + 2'h1 : rst_cnt;
            end else begin
                rst_cnt <= 2'h0;
            end
        end
    end

    // ==========================================================
    // Request intake
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (!rst_n) begin
                req_ready <= 1'b0;
                pending <= 1'b0;
                cur <= '0;
            end else if (req_valid && req_ready) begin
                cur <= req_data;
                pending <= 1'b1;
                req_ready <= 1'b0;
            end else if (tick && state == ST_T4) begin
                pending <= 1'b0;
                req_ready <= 1'b1;
            end else if (!pending) begin
                req_ready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Bus cycle sequencer and pins
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (!rst_n) begin
                state <= ST_IDLE;
                rsp_valid <= 1'b0;
                rsp_rdata <= 16'h0;
                transceiver_enable_n <= 1'b1;
                read_strobe_n <= 1'b1;
                write_strobe_n <= 1'b1;
                transceiver_enable_oe <= drive;
                read_strobe_oe <= drive;
                write_strobe_oe <= drive;
                bus_cycle_status <= `RSBI_STAT_PASSIVE;
                bus_cycle_status_oe <= drive;
                bus_lock_out_n <= 1'b1;
                bus_lock_out_oe <= drive;
                muxed_addr_data_o <= 16'h0;
                muxed_addr_data_oe <= 1'b0;
                upper_address_o <= 4'h0;
                upper_address_oe <= 1'b0;
                high_byte_enable_n <= 1'b1;
                high_byte_enable_oe <= 1'b0;
                transceiver_direction <= 1'b0;
                transceiver_direction_oe <= 1'b0;
                address_latch_strobe <= 1'b0;
                address_latch_oe <= 1'b1;
                bus_grant_out <= 1'b0;
                bus_grant_oe <= 1'b1;
                mem_select_n <= 4'hf;
                mem_select_oe <= 1'b0;
            end else begin
                rsp_valid <= 1'b0;
                mem_select_oe <= 1'b1;
                bus_lock_out_oe <= 1'b1;
                bus_grant_oe <= 1'b1;
                address_latch_oe <= 1'b1;
                if (tick) begin
                    unique case (state)
                        ST_IDLE: begin
                            // Hold wins over a queued request
                            if (hold_req) begin
                                state <= ST_HOLD;
                                bus_grant_out <= 1'b1;
                                read_strobe_oe <= 1'b0;
                                write_strobe_oe <= 1'b0;
                                transceiver_enable_oe <= 1'b0;
                                bus_cycle_status_oe <= 1'b0;
                                transceiver_direction_oe <= 1'b0;
                            end else begin
                                read_strobe_oe <= 1'b1;
                                write_strobe_oe <= 1'b1;
                                transceiver_enable_oe <= 1'b1;
                                bus_cycle_status_oe <= 1'b1;
                                transceiver_direction_oe <= 1'b1;
                                if (pending) begin
                                    state <= ST_T1;
                                    address_latch_strobe <= 1'b1;
                                    muxed_addr_data_o <= cur.addr[15:0];
                                    muxed_addr_data_oe <= 1'b1;
                                    upper_address_o <= cur.addr[19:16];
                                    upper_address_oe <= 1'b1;
                                    high_byte_enable_n <= 1'b0;
                                    high_byte_enable_oe <= 1'b1;
                                    transceiver_direction <= cur.write;
                                    bus_cycle_status <= cur.write ? `RSBI_STAT_MEM_WR
                                        : `RSBI_STAT_MEM_RD;
                                end
                            end
                        end
                        ST_T1: begin
                            state <= ST_T2;
                            address_latch_strobe <= 1'b0;
                            transceiver_enable_n <= 1'b0;
                            if (cur.write) begin
                                muxed_addr_data_o <= cur.wdata;
                                write_strobe_n <= 1'b0;
                            end else begin
                                muxed_addr_data_oe <= 1'b0;
                                read_strobe_n <= 1'b0;
                            end
                        end
                        ST_T2: begin
                            state <= ST_T3;
                        end
                        ST_T3, ST_TW: begin
                            if (bus_ready) begin
                                state <= ST_T4;
                                if (!cur.write) begin
                                    rsp_rdata <= muxed_addr_data_i;
                                end
                                read_strobe_n <= 1'b1;
                                write_strobe_n <= 1'b1;
                                bus_cycle_status <= `RSBI_STAT_PASSIVE;
                            end else begin
                                state <= ST_TW;
                            end
                        end
                        ST_T4: begin
                            state <= ST_IDLE;
                            rsp_valid <= 1'b1;
                            transceiver_enable_n <= 1'b1;
                            muxed_addr_data_oe <= 1'b0;
                            upper_address_oe <= 1'b0;
                            high_byte_enable_n <= 1'b1;
                            high_byte_enable_oe <= 1'b0;
                        end
                        ST_HOLD: begin
                            if (!hold_req) begin
                                state <= ST_IDLE;
                                bus_grant_out <= 1'b0;
                            end
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
                // Queue mode borrows the latch and write pins
                if (mode.queue_status) begin
                    address_latch_strobe <= queue_state_in[0];
                    write_strobe_n <= queue_state_in[1];
                end
                // Test mode lets a tester own every pin that has an enable
                if (mode.pin_float) begin
                    muxed_addr_data_oe <= 1'b0;
                    upper_address_oe <= 1'b0;
                    high_byte_enable_oe <= 1'b0;
                    address_latch_oe <= 1'b0;
                    read_strobe_oe <= 1'b0;
                    write_strobe_oe <= 1'b0;
                    transceiver_enable_oe <= 1'b0;
                    transceiver_direction_oe <= 1'b0;
                    bus_cycle_status_oe <= 1'b0;
                    bus_lock_out_oe <= 1'b0;
                    bus_grant_oe <= 1'b0;
                    mem_select_oe <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // States counted per cycle, used only by checks
    always_ff @(posedge core_clk) begin
        if (ce && (!rst_n || state == ST_IDLE)) begin
            st_cnt <= 4'h0;
        end else if (ce && tick && st_cnt != 4'hf) begin
            st_cnt <= st_cnt + 4'h1;
        end
    end

    chk_min_states: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ce && tick && state == ST_T4) |-> st_cnt >= `RSBI_MIN_STATES - 4'h1)
        else $error("bus cycle shorter than four states");

    chk_wait_extend: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ce && tick && (state == ST_T3 || state == ST_TW) && !bus_ready)
        |=> state == ST_TW)
        else $error("not-ready did not insert a wait state");

    chk_hold_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_grant_out |-> !muxed_addr_data_oe && !read_strobe_oe && !write_strobe_oe
        && !upper_address_oe)
        else $error("bus driven while granted");

    chk_reset_drive: assert property (@(posedge core_clk)
        (rst_n && ce) ##1 (!rst_n && ce) |=> read_strobe_oe && read_strobe_n
        && write_strobe_oe && transceiver_enable_oe && bus_cycle_status_oe
        && bus_cycle_status == `RSBI_STAT_PASSIVE && bus_lock_out_oe)
        else $error("strobes not driven high at reset entry");

    chk_reset_release: assert property (@(posedge core_clk)
        (!rst_n && ce) [*3] |=> !read_strobe_oe && !write_strobe_oe
        && !transceiver_enable_oe && !bus_cycle_status_oe && !bus_lock_out_oe)
        else $error("reset drivers not released");

    chk_reset_float: assert property (@(posedge core_clk)
        (!rst_n && ce) |=> !muxed_addr_data_oe && !upper_address_oe
        && !high_byte_enable_oe && !transceiver_direction_oe)
        else $error("bus not floated in reset");

    chk_latch_grant_low: assert property (@(posedge core_clk)
        (!rst_n && ce) |=> address_latch_oe && !address_latch_strobe
        && bus_grant_oe && !bus_grant_out)
        else $error("latch strobe or grant not low in reset");

    chk_queue_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ce && mode.queue_status) |=> address_latch_strobe == $past(queue_state_in[0])
        && write_strobe_n == $past(queue_state_in[1]))
        else $error("queue state not on borrowed pins");

    chk_pullup_on: assert property (@(posedge core_clk)
        (!rst_n && ce) |=> strap_pullup_en == `RSBI_PU_ALL)
        else $error("pull-ups not enabled in reset");
endmodule : rsbi_top

// ==== tb/rsbi_bus_dev.sv ====
// Purpose: Local bus memory model facing rsbi_top
// Assumes: Ready is held low for nwait core cycles of each strobe
// Notes: Returns a fixed read word; a released bus shows the inverted last value
`timescale 1ns/10ps

module rsbi_bus_dev (
    input wire logic clk, // Core clock
    input wire logic rd_n, // Read strobe
    input wire logic wr_n, // Write strobe
    input wire logic [15:0] ad_o, // Bus from device
    input wire logic ad_oe, // Device drives bus
    input wire logic [3:0] nwait, // Wait length
    output logic rdy, // Ready to device
    output logic [15:0] ad_i // Bus level seen by device
);
    logic [3:0] cnt = 4'h0;
    always_ff @(posedge clk) begin
        cnt <= (rd_n & wr_n) ? 4'h0 : cnt + 4'h1;
    end
    assign rdy = (cnt >= nwait);
    // Inverted value so a stale bus can never pass for fresh data
    assign ad_i = ad_oe ? ad_o : (rd_n ? ~ad_o : 16'hc35a);
endmodule : rsbi_bus_dev

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for rsbi_top
// Assumes: Inputs change by NBA at rising edge, checks at falling edge
// Notes: Split pins are resolved from their enables
`timescale 1ns/10ps

module testbench;
    import rsbi_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b1, req_valid = 1'b0, hold_req = 1'b0;
    logic strap = 1'b1, busy = 1'b1, rd_i, rdy, req_ready, rsp_valid, grant, grant_oe;
    logic pco, ad_oe, ale, ale_oe, rd_n, rd_oe, wr_n, wr_oe, ten_n, ten_oe, dir, dir_oe;
    logic st_oe, lock_n, lock_oe, up_oe, reset_out, sel_oe, hbe_n, hbe_oe;
    logic tie = 1'b0, ce = 1'b1;
    logic [1:0] qs = 2'h0;
    logic [2:0] st;
    logic [3:0] sel = 4'hf, nwait = 4'h0, up, sel_n, sel_i;
    logic [5:0] pu;
    logic [15:0] rsp_rdata, ad_i, ad_o;
    rsbi_req_s req = '0;
    rsbi_mode_s mode;
    int n_mismatch = 0, total_checks = 0, base, n;
    always #50 core_clk = ~core_clk;
    assign rd_i = rd_oe ? rd_n : strap;
    assign sel_i = sel_oe ? sel_n : sel;
    rsbi_top uut (.core_clk, .rst_n, .ce, .req_data(req), .req_valid, .req_ready,
        .rsp_valid, .rsp_rdata, .queue_state_in(qs), .bus_ready(rdy), .hold_req,
        .bus_grant_out(grant), .bus_grant_oe(grant_oe), .processor_clock_out(pco),
        .muxed_addr_data_i(ad_i), .muxed_addr_data_o(ad_o), .muxed_addr_data_oe(ad_oe),
        .upper_address_o(up), .upper_address_oe(up_oe), .high_byte_enable_n(hbe_n),
        .high_byte_enable_oe(hbe_oe), .address_latch_strobe(ale), .address_latch_oe(ale_oe),
        .read_strobe_queue_strap_i(rd_i), .read_strobe_n(rd_n), .read_strobe_oe(rd_oe),
        .write_strobe_n(wr_n), .write_strobe_oe(wr_oe), .transceiver_enable_n(ten_n),
        .transceiver_enable_oe(ten_oe), .transceiver_direction(dir),
        .transceiver_direction_oe(dir_oe), .bus_cycle_status(st), .bus_cycle_status_oe(st_oe),
        .bus_lock_out_n(lock_n), .bus_lock_out_oe(lock_oe), .mem_select_i(sel_i),
        .mem_select_n(sel_n), .mem_select_oe(sel_oe),
        .coproc_busy_test_in(tie ? reset_out : busy),
        .strap_pullup_en(pu), .reset_out, .mode);
    rsbi_bus_dev dev (.clk(core_clk), .rd_n, .wr_n, .ad_o, .ad_oe, .nwait, .rdy, .ad_i);
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic t_reset(input logic r, input logic [3:0] s, input logic b);
        @(posedge core_clk);
        rst_n <= 1'b0;
        strap <= r;
        sel <= s;
        busy <= b;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            // Third reset edge: release, busy goes high for the enhanced strap
            if (i == 2) begin
                rst_n <= 1'b1;
                busy <= 1'b1;
            end
            @(negedge core_clk);
            chk("rst oe", {rd_oe, wr_oe, ten_oe, st_oe, lock_oe}, {5{i < 2}});
            if (i < 2) chk("rst lvl", {rd_n, wr_n, ten_n, st, lock_n}, 7'h7f);
            chk("float", {ad_oe, up_oe, dir_oe, hbe_oe, ale, ale_oe, grant, grant_oe},
                8'h05);
            chk("pullup", {pu, reset_out, pco}, 8'hfe);
        end
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("mode", mode, {~r, s[1:0] == 2'h0, ~b});
        chk("sel", {sel_oe, sel_n}, {s[1:0] != 2'h0, 4'hf});
        chk("pullup off", pu, 6'h00);
    endtask : t_reset
    task automatic t_queue();
        for (int q = 0; q < 4; q++) begin
            @(posedge core_clk);
            qs <= q[1:0];
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("queue pins", {wr_n, ale}, q[1:0]);
        end
    endtask : t_queue
    task automatic t_cycle(input logic w, input logic [19:0] a, input logic [15:0] d, output int k);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{w, a, d};
        @(posedge core_clk);
        req_valid <= 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 200) begin
            @(negedge core_clk);
            k++;
            if (ale === 1'b1) chk("addr", {st, dir, up, ad_o}, {w ? 3'h6 : 3'h5, w, a});
            if (ale === 1'b1) chk("hbe", {hbe_oe, hbe_n}, 2'h2);
            if (wr_n === 1'b0) chk("wdata", {ten_n, ad_oe, ad_o}, {2'h1, d});
            if (rd_n === 1'b0) chk("rd xcvr", {ten_n, dir, ad_oe}, 3'h0);
        end
        // Four states of two oscillator cycles each
        chk("rsp", rsp_valid, 1'b1);
        chk("states", k >= 8, 1'b1);
        if (!w) chk("rdata", rsp_rdata, 16'hc35a);
    endtask : t_cycle
    task automatic t_freeze();
        logic p;
        @(posedge core_clk);
        ce <= 1'b0;
        @(negedge core_clk);
        p = pco;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("freeze", pco, p);
        @(posedge core_clk);
        ce <= 1'b1;
    endtask : t_freeze
    task automatic t_hold();
        int k;
        @(posedge core_clk);
        hold_req <= 1'b1;
        k = 0;
        while (grant !== 1'b1 && k < 4) begin
            @(negedge core_clk);
            k++;
        end
        chk("grant", {grant, rd_oe, wr_oe, st_oe, dir_oe, ad_oe}, 6'h20);
        @(posedge core_clk);
        hold_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk("ungrant", grant, 1'b0);
    endtask : t_hold
    initial begin
        t_reset(1'b0, 4'hf, 1'b1);
        t_queue();
        t_reset(1'b1, 4'hc, 1'b0);
        chk("float all", {ale_oe, grant_oe, rd_oe, ad_oe}, 4'h0);
        @(posedge core_clk);
        tie <= 1'b1;
        t_reset(1'b1, 4'hf, 1'b0);
        @(posedge core_clk);
        tie <= 1'b0;
        t_reset(1'b1, 4'hf, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            chk("clk out", pco, i[0]);
        end
        t_freeze();
        t_cycle(1'b1, 20'habcde, 16'h1234, base);
        t_cycle(1'b0, 20'h5a5a5, 16'h0000, base);
        @(posedge core_clk);
        nwait <= 4'h8;
        t_cycle(1'b0, 20'hfffff, 16'h0000, n);
        chk("waits", n > base, 1'b1);
        t_hold();
        conclude();
    end
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule : testbench
